// file: logic/dsb_pkg.sv
// Function
// - Both selects sampled on every input clock rise; address taken only on rises that accept a command.
// - Write beats one and three, with masks, taken on input clock rises.
// - Write beats two and four, with masks, taken on complement rises.
// - Read and write addresses share pins, both taken on input clock rises; a read wins a shared edge.
// - Each byte mask travels with its beat and gates its own lane.
// - A write lasts two cycles; writes are taken every second cycle.
// - A read lasts two cycles; reads are taken every second cycle.
// - With the DLL on, read beats one and three leave on third and fourth complement rises.
// - With the DLL on, read beats two and four leave on fourth and fifth input rises.
// - Every read and every write moves exactly four beats.
// - Reads and writes run at once on separate ports, no turnaround.
// - Echo clock pair is driven aligned with the read data beats.
// - Width is 36 bits by 512K words or 18 bits by 1M words.
// - Valid flag is high while read data is valid, aligned to echo.
// - Echo clocks run continuously, also while read data is idle.
// - With the DLL bypassed, read latency is 1.0 cycle, to 167 MHz.
// - Address is ignored on edges with neither read nor write selected.
`default_nettype none
package dsb_pkg;
	localparam int BURST_LEN = 4;
	localparam int BEAT_IDX_W = 2;
	localparam int LANE_W = 9;
	localparam int DATA_W_WIDE = 36;
	localparam int ADDR_W_WIDE = 17;
	localparam int DATA_W_NARROW = 18;
	localparam int ADDR_W_NARROW = 18;
	localparam int BYPASS_MAX_MHZ = 167;
	localparam int SYNC_STAGES = 2;
endpackage
`default_nettype wire

// file: logic/dsb_port.sv
`timescale 1ns/1ps
`default_nettype none
module dsb_port #(
	parameter int DATA_W = dsb_pkg::DATA_W_WIDE,
	parameter int ADDR_W = dsb_pkg::ADDR_W_WIDE
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic k_clk,
	input wire logic [ADDR_W-1:0] address_in,
	input wire logic rd_sel_n,
	input wire logic wr_sel_n,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic [DATA_W/dsb_pkg::LANE_W-1:0] byte_lane_mask_n,
	input wire logic dll_enable,
	output logic [DATA_W-1:0] rd_data,
	output logic rd_data_oe,
	output logic echo_clock_true,
	output logic echo_clock_comp,
	output logic output_valid_flag,
	output logic read_done_pulse,
	output logic write_done_pulse
);
	import dsb_pkg::*;

	localparam int LANES = DATA_W / LANE_W;
	localparam int MEM_W = ADDR_W + BEAT_IDX_W;

	// Storage: one word per beat, burst base address plus beat index
	logic [DATA_W-1:0] mem [0:(1<<MEM_W)-1];

	// Bypass strap is asynchronous to the link clock, so synchronise it
	logic dll_s1_r;
	logic dll_s2_r;
	always_ff @(posedge k_clk or posedge rst) begin
		if (rst) begin
			dll_s1_r <= 1'b0;
			dll_s2_r <= 1'b0;
		end else begin
			dll_s1_r <= dll_enable;
			dll_s2_r <= dll_s1_r;
		end
	end
	wire bypass = !dll_s2_r;

	// Command pipelines, one stage per input clock cycle
	logic rp1_r, rp2_r, rp3_r, rp4_r;
	logic wp1_r, wp2_r, wp3_r;
	logic [ADDR_W-1:0] radr1_r, radr2_r;
	logic [ADDR_W-1:0] wadr1_r, wadr2_r, wadr3_r;

	// Busy stage blocks a second command; a read wins a shared edge
	wire rd_take = !rd_sel_n && !rp1_r;
	wire wr_take = !wr_sel_n && !wp1_r && !rd_take;

	always_ff @(posedge k_clk or posedge rst) begin
		if (rst) begin
			rp1_r <= 1'b0;
			rp2_r <= 1'b0;
			rp3_r <= 1'b0;
			rp4_r <= 1'b0;
			wp1_r <= 1'b0;
			wp2_r <= 1'b0;
			wp3_r <= 1'b0;
		end else begin
			rp1_r <= rd_take;
			rp2_r <= rp1_r;
			rp3_r <= rp2_r;
			rp4_r <= rp3_r;
			wp1_r <= wr_take;
			wp2_r <= wp1_r;
			wp3_r <= wp2_r;
		end
	end

	// First address stages load only on an accepted command; later stages shift every cycle
	always_ff @(posedge k_clk or posedge rst) begin
		if (rst) begin
			radr1_r <= '0;
			radr2_r <= '0;
			wadr1_r <= '0;
			wadr2_r <= '0;
			wadr3_r <= '0;
		end else begin
			if (rd_take)
				radr1_r <= address_in;
			if (wr_take)
				wadr1_r <= address_in;
			radr2_r <= radr1_r;
			wadr2_r <= wadr1_r;
			wadr3_r <= wadr2_r;
		end
	end

	// Write buffer: odd beats on the rise, even beats on the fall
	logic [DATA_W-1:0] wdp_r [0:1];
	logic [LANES-1:0] wmp_r [0:1];
	logic [DATA_W-1:0] wdn_r [0:1];
	logic [LANES-1:0] wmn_r [0:1];

	always_ff @(posedge k_clk or posedge rst) begin
		if (rst) begin
			wdp_r[0] <= '0;
			wdp_r[1] <= '0;
			wmp_r[0] <= '1;
			wmp_r[1] <= '1;
		end else begin
			if (wp1_r) begin
				wdp_r[0] <= wr_data;
				wmp_r[0] <= byte_lane_mask_n;
			end
			if (wp2_r) begin
				wdp_r[1] <= wr_data;
				wmp_r[1] <= byte_lane_mask_n;
			end
		end
	end

	// Falling edge of the input clock stands in for the complement clock
	always_ff @(negedge k_clk or posedge rst) begin
		if (rst) begin
			wdn_r[0] <= '0;
			wdn_r[1] <= '0;
			wmn_r[0] <= '1;
			wmn_r[1] <= '1;
		end else begin
			if (wp2_r) begin
				wdn_r[0] <= wr_data;
				wmn_r[0] <= byte_lane_mask_n;
			end
			if (wp3_r) begin
				wdn_r[1] <= wr_data;
				wmn_r[1] <= byte_lane_mask_n;
			end
		end
	end

	logic [DATA_W-1:0] beat_d [0:BURST_LEN-1];
	logic [LANES-1:0] beat_m [0:BURST_LEN-1];
	assign beat_d[0] = wdp_r[0];
	assign beat_d[1] = wdn_r[0];
	assign beat_d[2] = wdp_r[1];
	assign beat_d[3] = wdn_r[1];
	assign beat_m[0] = wmp_r[0];
	assign beat_m[1] = wmn_r[0];
	assign beat_m[2] = wmp_r[1];
	assign beat_m[3] = wmn_r[1];

	// Whole burst commits one edge after beat four has landed
	always_ff @(posedge k_clk) begin
		if (wp3_r) begin
			for (int b = 0; b < BURST_LEN; b++) begin
				for (int l = 0; l < LANES; l++) begin
					if (!beat_m[b][l])
						mem[{wadr3_r, BEAT_IDX_W'(b)}][l*LANE_W +: LANE_W]
							<= beat_d[b][l*LANE_W +: LANE_W];
				end
			end
		end
	end

	// Read fetch: bypass fetches one cycle earlier to meet its latency
	wire [ADDR_W-1:0] fetch_adr = bypass ? radr1_r : radr2_r;
	wire fetch_go = bypass ? rp1_r : rp2_r;
	// Burst committing on the fetch edge is merged in by lane
	wire wbuf_hit = wp3_r && (wadr3_r == fetch_adr);
	logic [DATA_W-1:0] fw [0:BURST_LEN-1];

	genvar gb, gl;
	generate
		for (gb = 0; gb < BURST_LEN; gb++) begin : g_beat
			for (gl = 0; gl < LANES; gl++) begin : g_lane
				assign fw[gb][gl*LANE_W +: LANE_W] =
					(wbuf_hit && !beat_m[gb][gl]) ?
					beat_d[gb][gl*LANE_W +: LANE_W] :
					mem[{fetch_adr, BEAT_IDX_W'(gb)}][gl*LANE_W +: LANE_W];
			end
		end
	endgenerate

	logic [DATA_W-1:0] rbuf_r [0:BURST_LEN-1];
	always_ff @(posedge k_clk or posedge rst) begin
		if (rst) begin
			for (int b = 0; b < BURST_LEN; b++)
				rbuf_r[b] <= '0;
		end else if (fetch_go) begin
			for (int b = 0; b < BURST_LEN; b++)
				rbuf_r[b] <= fw[b];
		end
	end

	// Launch selection; DLL mode gives 2.5 cycles, bypass 1.0 cycle
	logic [DATA_W-1:0] qp_nxt, qn_nxt;
	logic vp_nxt, vn_nxt;
	assign qp_nxt = (bypass && rp1_r) ? fw[0] :
		(bypass && rp2_r) ? rbuf_r[2] :
		(!bypass && rp3_r) ? rbuf_r[1] :
		(!bypass && rp4_r) ? rbuf_r[3] : '0;
	assign qn_nxt = (bypass && rp2_r) ? rbuf_r[1] :
		(bypass && rp3_r) ? rbuf_r[3] :
		(!bypass && rp3_r) ? rbuf_r[0] :
		(!bypass && rp4_r) ? rbuf_r[2] : '0;
	assign vp_nxt = bypass ? (rp1_r || rp2_r) : (rp3_r || rp4_r);
	assign vn_nxt = bypass ? (rp2_r || rp3_r) : (rp3_r || rp4_r);

	logic [DATA_W-1:0] qp_r, qn_r;
	logic vp_r, vn_r;
	always_ff @(posedge k_clk or posedge rst) begin
		if (rst) begin
			qp_r <= '0;
			vp_r <= 1'b0;
		end else begin
			qp_r <= qp_nxt;
			vp_r <= vp_nxt;
		end
	end
	always_ff @(negedge k_clk or posedge rst) begin
		if (rst) begin
			qn_r <= '0;
			vn_r <= 1'b0;
		end else begin
			qn_r <= qn_nxt;
			vn_r <= vn_nxt;
		end
	end

	// Clock-selected output stage, the usual double-rate output mux
	assign rd_data = k_clk ? qp_r : qn_r;
	assign rd_data_oe = k_clk ? vp_r : vn_r;
	assign output_valid_flag = k_clk ? vp_r : vn_r;
	// Echo follows the input clock; free running, not gated by valid
	assign echo_clock_true = k_clk;
	assign echo_clock_comp = !k_clk;

	// Read acceptance and write commit events cross to clk as toggles
	logic rd_tgl_r, wr_tgl_r;
	always_ff @(posedge k_clk or posedge rst) begin
		if (rst) begin
			rd_tgl_r <= 1'b0;
			wr_tgl_r <= 1'b0;
		end else begin
			rd_tgl_r <= rd_tgl_r ^ rd_take;
			wr_tgl_r <= wr_tgl_r ^ wp3_r;
		end
	end

	logic [2:0] rd_sy_r, wr_sy_r;
	logic rd_pulse_r, wr_pulse_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_sy_r <= 3'h0;
			wr_sy_r <= 3'h0;
			rd_pulse_r <= 1'b0;
			wr_pulse_r <= 1'b0;
		end else begin
			rd_sy_r <= {rd_sy_r[1:0], rd_tgl_r};
			wr_sy_r <= {wr_sy_r[1:0], wr_tgl_r};
			rd_pulse_r <= rd_sy_r[2] ^ rd_sy_r[1];
			wr_pulse_r <= wr_sy_r[2] ^ wr_sy_r[1];
		end
	end
	assign read_done_pulse = rd_pulse_r;
	assign write_done_pulse = wr_pulse_r;

	// A repeat select right behind a read must not enter the pipeline
	property p_rd_spacing;
		@(posedge k_clk) disable iff (rst)
		(rp1_r && !rd_sel_n) |=> !rp1_r;
	endproperty
	a_rd_spacing: assert property (p_rd_spacing)
		else $error("read accepted on two adjacent edges");

	property p_wr_spacing;
		@(posedge k_clk) disable iff (rst)
		(wp1_r && !wr_sel_n) |=> !wp1_r;
	endproperty
	a_wr_spacing: assert property (p_wr_spacing)
		else $error("write accepted on two adjacent edges");

	property p_shared_edge;
		@(posedge k_clk) disable iff (rst)
		!(rd_take && wr_take);
	endproperty
	a_shared_edge: assert property (p_shared_edge)
		else $error("read and write taken on one edge");

	property p_deselect;
		@(posedge k_clk) disable iff (rst)
		(rd_sel_n && wr_sel_n) |=> ($stable(radr1_r) && $stable(wadr1_r));
	endproperty
	a_deselect: assert property (p_deselect)
		else $error("address loaded while deselected");

	property p_dll_valid;
		@(posedge k_clk) disable iff (rst)
		(rd_take && dll_s2_r) |-> ##3 !vp_r ##1 vp_r ##1 vp_r;
	endproperty
	a_dll_valid: assert property (p_dll_valid)
		else $error("valid window not at 2.5 cycle latency");

	property p_dll_beat2;
		@(posedge k_clk) disable iff (rst)
		(rd_take && dll_s2_r) |->
			##4 (qp_r == $past(rbuf_r[1]));
	endproperty
	a_dll_beat2: assert property (p_dll_beat2)
		else $error("beat two not launched on fourth rise");

	property p_burst_four;
		@(posedge k_clk) disable iff (rst)
		wr_take |=> wp1_r ##1 wp2_r ##1 (wp3_r && !wp2_r);
	endproperty
	a_burst_four: assert property (p_burst_four)
		else $error("write burst pipeline out of step");

	property p_bypass_lat;
		@(posedge k_clk) disable iff (rst)
		(rd_take && bypass) |-> ##1 !vp_r ##1 vp_r;
	endproperty
	a_bypass_lat: assert property (p_bypass_lat)
		else $error("bypass read not at 1.0 cycle latency");
endmodule
`default_nettype wire

// file: tb/dsb_host.sv
`timescale 1ns/1ps
`default_nettype none
module dsb_host #(
	parameter int DW = 36,
	parameter int AW = 6
) (
	output logic k_clk,
	output logic [AW-1:0] address_in,
	output logic rd_sel_n,
	output logic wr_sel_n,
	output logic [DW-1:0] wr_data,
	output logic [DW/dsb_pkg::LANE_W-1:0] byte_lane_mask_n,
	input wire logic [DW-1:0] rd_data,
	input wire logic output_valid_flag,
	input wire logic echo_clock_true
);
	import dsb_pkg::*;
	initial begin
		k_clk = 0;
		#7;
		forever #62.5 k_clk = ~k_clk;
	end
	initial begin
		rd_sel_n = 1;
		wr_sel_n = 1;
		address_in = '0;
		wr_data = '0;
		byte_lane_mask_n = '1;
	end
	// A second edge with the select held low is a refused repeat
	task automatic wr(input logic [AW-1:0] a, a2, input logic [DW-1:0] d[4],
		input logic [DW/LANE_W-1:0] m[4], input bit dbl);
		@(negedge k_clk);
		wr_sel_n <= 0;
		address_in <= a;
		@(negedge k_clk);
		wr_sel_n <= !dbl;
		if (dbl) address_in <= a2;
		for (int i = 0; i < 4; i++) begin
			if (i > 0) @(k_clk);
			wr_data <= d[i];
			byte_lane_mask_n <= m[i];
			if (i == 2) wr_sel_n <= 1;
		end
		@(k_clk);
		// Released lines flip so a stale beat cannot pass for a held one
		wr_data <= ~d[3];
		byte_lane_mask_n <= '1;
	endtask
	task automatic rd(input logic [AW-1:0] a, a2, input bit dll, dbl,
		output logic [DW-1:0] q[4], output logic [4:0] fl,
		output logic [3:0] ec);
		@(negedge k_clk);
		rd_sel_n <= 0;
		address_in <= a;
		@(negedge k_clk);
		if (dbl) begin
			address_in <= a2;
			@(negedge k_clk);
		end
		rd_sel_n <= 1;
		repeat (dll ? 2 - dbl : 0) @(negedge k_clk);
		if (!dll) @(posedge k_clk);
		for (int i = 0; i < 5; i++) begin
			if (i > 0) @(k_clk);
			#30;
			if (i < 4) q[i] = rd_data;
			if (i < 4) ec[i] = echo_clock_true;
			fl[i] = output_valid_flag;
		end
	endtask
endmodule
`default_nettype wire

// file: tb/dsb_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dsb_port_tb_top;
	import dsb_pkg::*;
	localparam int DW = DATA_W_WIDE;
	localparam int AW = 6;
	localparam int MW = DW / LANE_W;
	typedef logic [DW-1:0] dsb_beats_t [4];
	localparam logic [MW-1:0] MSK [4] = '{4'hE, 4'hD, 4'hB, 4'h7};
	localparam logic [MW-1:0] ZM [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
	logic clk, rst, dll_enable, k_clk, rs_n, ws_n, oe, ect, ecc, ovf, rdp, wdp;
	logic [AW-1:0] addr;
	logic [DW-1:0] wd, rdd;
	logic [MW-1:0] bm;
	dsb_beats_t m3;
	int n_errors = 0, num_checks = 0, n_rd = 0, n_wr = 0;
	dsb_port #(.DATA_W(DW), .ADDR_W(AW)) dut_u (.clk(clk), .rst(rst),
		.k_clk(k_clk), .address_in(addr), .rd_sel_n(rs_n), .wr_sel_n(ws_n),
		.wr_data(wd), .byte_lane_mask_n(bm), .dll_enable(dll_enable),
		.rd_data(rdd), .rd_data_oe(oe), .echo_clock_true(ect),
		.echo_clock_comp(ecc), .output_valid_flag(ovf),
		.read_done_pulse(rdp), .write_done_pulse(wdp));
	dsb_host #(.DW(DW), .AW(AW)) host_u (.k_clk(k_clk), .address_in(addr),
		.rd_sel_n(rs_n), .wr_sel_n(ws_n), .wr_data(wd),
		.byte_lane_mask_n(bm), .rd_data(rdd), .output_valid_flag(ovf),
		.echo_clock_true(ect));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always @(negedge clk) begin
		if (rdp === 1'b1) n_rd++;
		if (wdp === 1'b1) n_wr++;
	end
	// Echo pair and output enable are judged mid half cycle
	always @(k_clk) begin
		#30;
		check(DW'(ect), DW'(k_clk), "echo true");
		check(DW'(ecc), DW'(!k_clk), "echo complement");
		check(DW'(oe), DW'(ovf), "output enable");
	end
	task automatic check(input logic [DW-1:0] seen, exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	function automatic dsb_beats_t pat(int s);
		for (int i = 0; i < 4; i++) pat[i] = {4{9'(s * 8 + i)}};
	endfunction
	function automatic dsb_beats_t mrg(dsb_beats_t o, n,
		logic [MW-1:0] m [4]);
		for (int i = 0; i < 4; i++)
			for (int l = 0; l < MW; l++)
				mrg[i][l*9+:9] = m[i][l] ? o[i][l*9+:9] : n[i][l*9+:9];
	endfunction
	task automatic rd_chk(input logic [AW-1:0] a, a2, input bit dll, dbl,
		input dsb_beats_t e);
		dsb_beats_t q;
		logic [4:0] fl;
		logic [3:0] ec;
		host_u.rd(a, a2, dll, dbl, q, fl, ec);
		for (int i = 0; i < 4; i++) check(q[i], e[i], "read beat");
		check(fl, 5'h0F, "valid flag");
		check(ec, dll ? 4'hA : 4'h5, "echo phase");
	endtask
	task automatic t_mask;
		host_u.wr(3, 3, pat(1), ZM, 0);
		host_u.wr(3, 3, pat(2), MSK, 0);
		m3 = mrg(pat(1), pat(2), MSK);
		rd_chk(3, 3, 1, 0, m3);
		$display("test mask done");
	endtask
	task automatic t_refuse;
		host_u.wr(10, 10, pat(5), ZM, 0);
		host_u.wr(9, 10, pat(4), ZM, 1);
		rd_chk(10, 10, 1, 0, pat(5));
		rd_chk(9, 10, 1, 1, pat(4));
		$display("test refuse done");
	endtask
	// Read follows the write by one edge, so the merge path is exercised
	task automatic t_conc;
		host_u.wr(20, 20, pat(6), ZM, 0);
		fork
			host_u.wr(20, 20, pat(7), MSK, 0);
			begin
				@(negedge k_clk);
				@(posedge k_clk);
				rd_chk(20, 20, 1, 0, mrg(pat(6), pat(7), MSK));
			end
		join
		$display("test concurrent done");
	endtask
	task automatic t_bypass;
		@(negedge clk) dll_enable <= 0;
		repeat (3) @(posedge k_clk);
		rd_chk(3, 3, 0, 0, m3);
		@(negedge clk) dll_enable <= 1;
		repeat (3) @(posedge k_clk);
		$display("test bypass done");
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#50000;
		n_errors++;
		give_verdict;
	end
	initial begin
		rst = 1;
		dll_enable = 1;
		repeat (2) @(posedge k_clk);
		repeat (5) @(negedge clk);
		rst <= 0;
		repeat (3) @(posedge k_clk);
		t_mask;
		t_refuse;
		t_conc;
		t_bypass;
		repeat (20) @(negedge clk);
		check(DW'(n_wr), DW'(6), "write count");
		check(DW'(n_rd), DW'(5), "read count");
		give_verdict;
	end
endmodule
`default_nettype wire
